//--- otss_selector.sv
// Multifunction digital output terminal selector for codes 0 and 26 to 39.
// What this block does
// - Code zero keeps the terminal OFF.
// - Codes 26-29, 34, 36 follow their detectors.
// - Code 30 ON when enabled, running and run time reaches setting.
// - Code 31 ON when analog input leaves window.
// - Code 32 ON while in load-off state.
// - Code 33 ON while running in reverse.
// - Code 35 ON when heatsink reaches threshold.
// - Code 37 ON at lower limit or stopped.
// - Code 38 alarm on fault that keeps running.
module otss_selector #(
    parameter int VAL_W = otss_pkg::VAL_W
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic [otss_pkg::SEL_W-1:0]  function_select,
    input  wire otss_pkg::otss_detect_t      detect,
    input  wire otss_pkg::otss_drive_t       drive,
    input  wire logic                        run_timer_function_select,
    input  wire logic [VAL_W-1:0]            run_elapsed_time,
    input  wire logic [VAL_W-1:0]            run_timer_setting,
    input  wire logic [VAL_W-1:0]            first_analog_input,
    input  wire logic [VAL_W-1:0]            analog_one_upper_protect_limit,
    input  wire logic [VAL_W-1:0]            analog_one_lower_protect_limit,
    input  wire logic [VAL_W-1:0]            heatsink_temp_reading,
    input  wire logic [VAL_W-1:0]            module_temp_arrival_threshold,
    output logic                             terminal_on
);
    logic timer_reached;
    logic temp_reached;
    logic ain_over;
    logic ain_under;
    logic ain_oow;
    logic stopped;
    logic select_on;
    logic out_reg;
    logic out_next;

    // Shared comparator instances for the threshold conditions.
    otss_cmp #(.W(VAL_W)) u_timer (
        .value       (run_elapsed_time),
        .limit       (run_timer_setting),
        .at_or_above (timer_reached)
    );
    otss_cmp #(.W(VAL_W)) u_temp (
        .value       (heatsink_temp_reading),
        .limit       (module_temp_arrival_threshold),
        .at_or_above (temp_reached)
    );

    // Window check is strict on both sides: equal to a limit stays inside.
    assign ain_over  = (first_analog_input > analog_one_upper_protect_limit);
    assign ain_under = (first_analog_input < analog_one_lower_protect_limit);
    assign ain_oow   = ain_over | ain_under;
    assign stopped   = ~drive.running;

    // Choose the condition named by the selection code.
    always_comb begin
        select_on = 1'b0;
        case (function_select)
            otss_pkg::SEL_NONE:      select_on = 1'b0;
            otss_pkg::SEL_FREQ1:     select_on = detect.freq_one_reached;
            otss_pkg::SEL_FREQ2:     select_on = detect.freq_two_reached;
            otss_pkg::SEL_CUR1:      select_on = detect.current_one_reached;
            otss_pkg::SEL_CUR2:      select_on = detect.current_two_reached;
            otss_pkg::SEL_TIMER:     select_on = run_timer_function_select & drive.running & timer_reached;
            otss_pkg::SEL_AIN_OOW:   select_on = ain_oow;
            otss_pkg::SEL_LOAD_OFF:  select_on = drive.load_off;
            otss_pkg::SEL_REVERSE:   select_on = drive.running & drive.reverse;
            otss_pkg::SEL_ZERO_CUR:  select_on = detect.zero_current;
            otss_pkg::SEL_HS_TEMP:   select_on = temp_reached;
            otss_pkg::SEL_SOFT_LIM:  select_on = detect.soft_current_limit;
            otss_pkg::SEL_LOW_LIM:   select_on = drive.at_lower_limit | stopped;
            otss_pkg::SEL_ALARM_RUN: select_on = drive.fault_active & drive.fault_keeps_running;
            default:                 select_on = 1'b0;
        endcase
    end

    // The terminal is registered so it never glitches while the code changes.
    always_comb begin
        out_next = select_on;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= otss_pkg::OUT_RESET;
        end else begin
            out_reg <= out_next;
        end
    end

    assign terminal_on = out_reg;

    // Assertions.
    property p_zero_off;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_NONE) |=> !terminal_on;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("Code zero drove terminal ON.");

    property p_freq1;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_FREQ1) |=> (terminal_on == $past(detect.freq_one_reached));
    endproperty
    a_freq1: assert property (p_freq1) else $error("Frequency one indication not followed.");

    property p_timer;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_TIMER && run_timer_function_select && drive.running
         && run_elapsed_time >= run_timer_setting) |=> terminal_on;
    endproperty
    a_timer: assert property (p_timer) else $error("Run timer arrival not shown.");

    property p_ain;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_AIN_OOW) |=>
        (terminal_on == ($past(first_analog_input) > $past(analog_one_upper_protect_limit)
                      || $past(first_analog_input) < $past(analog_one_lower_protect_limit)));
    endproperty
    a_ain: assert property (p_ain) else $error("Analog window flag wrong.");

    property p_load_off;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_LOAD_OFF) |=> (terminal_on == $past(drive.load_off));
    endproperty
    a_load_off: assert property (p_load_off) else $error("Load-off not followed.");

    property p_reverse;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_REVERSE && drive.running && drive.reverse) |=> terminal_on;
    endproperty
    a_reverse: assert property (p_reverse) else $error("Reverse running not shown.");

    property p_temp;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_HS_TEMP) |=>
        (terminal_on == ($past(heatsink_temp_reading) >= $past(module_temp_arrival_threshold)));
    endproperty
    a_temp: assert property (p_temp) else $error("Heatsink arrival wrong.");

    property p_low_lim;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_LOW_LIM && !drive.running) |=> terminal_on;
    endproperty
    a_low_lim: assert property (p_low_lim) else $error("Stopped drive not shown at lower limit.");

    property p_alarm;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_ALARM_RUN) |=>
        (terminal_on == ($past(drive.fault_active) && $past(drive.fault_keeps_running)));
    endproperty
    a_alarm: assert property (p_alarm) else $error("Alarm while running wrong.");

    // Two cycles on code 39 flush whatever the previous code left in the register.
    sequence s_reserved_held;
        (function_select == otss_pkg::SEL_RESERVED) [*2];
    endsequence

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        s_reserved_held |-> !terminal_on;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved code drove terminal ON.");

    // Every code outside zero and 26 to 38 must leave the terminal OFF one cycle later.
    property p_other_codes;
        @(posedge clk) disable iff (!rst_n)
        (function_select != otss_pkg::SEL_NONE
         && (function_select < otss_pkg::SEL_FREQ1
             || function_select > otss_pkg::SEL_ALARM_RUN)) |=> !terminal_on;
    endproperty
    a_other_codes: assert property (p_other_codes) else $error("Unused code drove terminal ON.");

    // The remaining detector codes follow their own indication with one cycle of delay.
    property p_freq2;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_FREQ2) |=> (terminal_on == $past(detect.freq_two_reached));
    endproperty
    a_freq2: assert property (p_freq2) else $error("Frequency two indication not followed.");

    property p_cur1;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_CUR1) |=> (terminal_on == $past(detect.current_one_reached));
    endproperty
    a_cur1: assert property (p_cur1) else $error("Current one indication not followed.");

    property p_cur2;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_CUR2) |=> (terminal_on == $past(detect.current_two_reached));
    endproperty
    a_cur2: assert property (p_cur2) else $error("Current two indication not followed.");

    property p_zero_cur;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_ZERO_CUR) |=> (terminal_on == $past(detect.zero_current));
    endproperty
    a_zero_cur: assert property (p_zero_cur) else $error("Zero current indication not followed.");

    property p_soft_lim;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_SOFT_LIM) |=> (terminal_on == $past(detect.soft_current_limit));
    endproperty
    a_soft_lim: assert property (p_soft_lim) else $error("Soft current limit not followed.");

    // Without enable, with a stopped drive or with time short of the setting, code 30 stays OFF.
    property p_timer_off;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_TIMER && !(run_timer_function_select && drive.running
         && run_elapsed_time >= run_timer_setting)) |=> !terminal_on;
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("Run timer shown before arrival.");

    // Forward running or a stopped drive must not light the reverse indication.
    property p_reverse_off;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_REVERSE && !(drive.running && drive.reverse)) |=> !terminal_on;
    endproperty
    a_reverse_off: assert property (p_reverse_off) else $error("Reverse shown while not reversing.");

    // While running, code 37 follows the lower limit indication alone.
    property p_low_lim_run;
        @(posedge clk) disable iff (!rst_n)
        (function_select == otss_pkg::SEL_LOW_LIM && drive.running) |=> (terminal_on == $past(drive.at_lower_limit));
    endproperty
    a_low_lim_run: assert property (p_low_lim_run) else $error("Lower limit not followed while running.");

    // Leaving load-off must drop the terminal exactly one cycle after the level fell.
    sequence s_load_off_drop;
        (function_select == otss_pkg::SEL_LOAD_OFF && drive.load_off)
        ##1 (function_select == otss_pkg::SEL_LOAD_OFF && !drive.load_off);
    endsequence

    property p_load_off_drop;
        @(posedge clk) disable iff (!rst_n)
        s_load_off_drop |-> terminal_on ##1 !terminal_on;
    endproperty
    a_load_off_drop: assert property (p_load_off_drop) else $error("Load-off release not followed.");
endmodule

//--- otss_pkg.sv
// Package with selection codes, widths and reset values for the output terminal selector.
package otss_pkg;
    localparam int SEL_W = 6;
    localparam int VAL_W = 16;
    localparam logic [5:0] SEL_NONE      = 6'h00;
    localparam logic [5:0] SEL_FREQ1     = 6'h1a;
    localparam logic [5:0] SEL_FREQ2     = 6'h1b;
    localparam logic [5:0] SEL_CUR1      = 6'h1c;
    localparam logic [5:0] SEL_CUR2      = 6'h1d;
    localparam logic [5:0] SEL_TIMER     = 6'h1e;
    localparam logic [5:0] SEL_AIN_OOW   = 6'h1f;
    localparam logic [5:0] SEL_LOAD_OFF  = 6'h20;
    localparam logic [5:0] SEL_REVERSE   = 6'h21;
    localparam logic [5:0] SEL_ZERO_CUR  = 6'h22;
    localparam logic [5:0] SEL_HS_TEMP   = 6'h23;
    localparam logic [5:0] SEL_SOFT_LIM  = 6'h24;
    localparam logic [5:0] SEL_LOW_LIM   = 6'h25;
    localparam logic [5:0] SEL_ALARM_RUN = 6'h26;
    localparam logic [5:0] SEL_RESERVED  = 6'h27;
    localparam logic       OUT_RESET     = 1'b0;

    // Detector indications that arrive from the drive core.
    typedef struct packed {
        logic freq_one_reached;
        logic freq_two_reached;
        logic current_one_reached;
        logic current_two_reached;
        logic zero_current;
        logic soft_current_limit;
    } otss_detect_t;

    // Drive state levels.
    typedef struct packed {
        logic running;
        logic load_off;
        logic reverse;
        logic at_lower_limit;
        logic fault_active;
        logic fault_keeps_running;
    } otss_drive_t;
endpackage

//--- otss_cmp.sv
// Threshold comparator: flags a value at or above a limit.
module otss_cmp #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] limit,
    output logic              at_or_above
);
    // Plain unsigned comparison; both sides share one scale.
    assign at_or_above = (value >= limit);
endmodule

//--- otss_load_model.sv
// Behavioural model of the equipment wired to the output terminal.
module otss_load_model (
    input  wire logic clk,
    input  wire logic terminal_on,
    output logic      lamp_lit
);
    timeunit 1ns;
    timeprecision 1ns;
    // The load only follows the terminal level; it never drives back into the block.
    always_ff @(posedge clk) begin
        lamp_lit <= terminal_on;
    end
endmodule

//--- otss_selector_tb.sv
// Self-checking testbench for the output terminal selector.
module otss_selector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        rst_n;
    logic [5:0]  fs;
    logic [5:0]  det;
    logic [5:0]  drv;
    logic        ten;
    logic [15:0] et, ts, ain, up, lo, hs, th;
    logic        terminal_on;
    int          num_errors;
    int          n_checks;

    otss_selector dut_u (.clk(clk), .rst_n(rst_n), .function_select(fs), .detect(det), .drive(drv),
        .run_timer_function_select(ten), .run_elapsed_time(et), .run_timer_setting(ts),
        .first_analog_input(ain), .analog_one_upper_protect_limit(up), .analog_one_lower_protect_limit(lo),
        .heatsink_temp_reading(hs), .module_temp_arrival_threshold(th), .terminal_on(terminal_on));
    otss_load_model load_u (.clk(clk), .terminal_on(terminal_on), .lamp_lit());

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // The output is registered, so it is judged one edge after the inputs were set.
    task automatic chk(input logic e);
        @(posedge clk);
        #1;
        n_checks++;
        if (terminal_on !== e) begin
            $display("wrong value terminal_on code %0d expected %b seen %b", fs, e, terminal_on);
            num_errors++;
        end
    endtask

    // Sets a code and the drive state, then checks the terminal.
    task automatic sc(input logic [5:0] c, input logic [5:0] d, input logic e);
        fs = c;
        drv = d;
        chk(e);
    endtask

    // Every condition active at once, so a code that must stay OFF is tested hard.
    task automatic t_quiet;
        det = 6'h3f;
        ten = 1'b1;
        et = 16'hffff;
        ain = 16'hffff;
        hs = 16'hffff;
        sc(otss_pkg::SEL_NONE, 6'h3f, 1'b0);
        sc(otss_pkg::SEL_RESERVED, 6'h3f, 1'b0);
        sc(6'h19, 6'h3f, 1'b0);
        sc(6'h28, 6'h3f, 1'b0);
        sc(6'h3f, 6'h3f, 1'b0);
    endtask

    // Each detector code must follow its own bit and ignore the other five.
    task automatic t_detect;
        logic [5:0] c [6];
        c = '{otss_pkg::SEL_FREQ1, otss_pkg::SEL_FREQ2, otss_pkg::SEL_CUR1, otss_pkg::SEL_CUR2,
              otss_pkg::SEL_ZERO_CUR, otss_pkg::SEL_SOFT_LIM};
        for (int i = 0; i < 6; i++) begin
            det = 6'h20 >> i;
            sc(c[i], 6'h00, 1'b1);
            det = ~(6'h20 >> i);
            sc(c[i], 6'h00, 1'b0);
        end
    endtask

    // Timer, window and temperature codes at their exact boundaries.
    task automatic t_values;
        ten = 1'b1;
        ts = 16'h0100;
        et = 16'h00ff;
        sc(otss_pkg::SEL_TIMER, 6'h20, 1'b0);
        et = 16'h0100;
        sc(otss_pkg::SEL_TIMER, 6'h20, 1'b1);
        ten = 1'b0;
        sc(otss_pkg::SEL_TIMER, 6'h20, 1'b0);
        ten = 1'b1;
        sc(otss_pkg::SEL_TIMER, 6'h00, 1'b0);
        up = 16'h0800;
        lo = 16'h0200;
        ain = 16'h0800;
        sc(otss_pkg::SEL_AIN_OOW, 6'h00, 1'b0);
        ain = 16'h0801;
        sc(otss_pkg::SEL_AIN_OOW, 6'h00, 1'b1);
        ain = 16'h0200;
        sc(otss_pkg::SEL_AIN_OOW, 6'h00, 1'b0);
        ain = 16'h01ff;
        sc(otss_pkg::SEL_AIN_OOW, 6'h00, 1'b1);
        th = 16'h0050;
        hs = 16'h004f;
        sc(otss_pkg::SEL_HS_TEMP, 6'h00, 1'b0);
        hs = 16'h0050;
        sc(otss_pkg::SEL_HS_TEMP, 6'h00, 1'b1);
    endtask

    // Drive-state codes, each driven ON and OFF on adjacent cycles.
    task automatic t_state;
        det = 6'h00;
        sc(otss_pkg::SEL_LOAD_OFF, 6'h10, 1'b1);
        sc(otss_pkg::SEL_LOAD_OFF, 6'h2f, 1'b0);
        sc(otss_pkg::SEL_REVERSE, 6'h28, 1'b1);
        sc(otss_pkg::SEL_REVERSE, 6'h37, 1'b0);
        sc(otss_pkg::SEL_REVERSE, 6'h08, 1'b0);
        sc(otss_pkg::SEL_LOW_LIM, 6'h20, 1'b0);
        sc(otss_pkg::SEL_LOW_LIM, 6'h24, 1'b1);
        sc(otss_pkg::SEL_LOW_LIM, 6'h00, 1'b1);
        sc(otss_pkg::SEL_ALARM_RUN, 6'h23, 1'b1);
        sc(otss_pkg::SEL_ALARM_RUN, 6'h22, 1'b0);
    endtask

    // A reset in mid-run drops a lit terminal at once; selection resumes after release.
    task automatic t_reset;
        sc(otss_pkg::SEL_LOW_LIM, 6'h00, 1'b1);
        rst_n = 1'b0;
        #1;
        n_checks++;
        if (terminal_on !== 1'b0) begin
            $display("wrong value terminal_on in reset expected 0 seen %b", terminal_on);
            num_errors++;
        end
        chk(1'b0);
        rst_n = 1'b1;
        chk(1'b1);
    endtask

    task automatic complete_run;
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The whole run is about 60 cycles; the watchdog allows far more.
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end

    // Main sequence: reset for 16 cycles, then the scenarios.
    initial begin
        num_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        {fs, det, drv, ten} = '0;
        {et, ts, ain, up, lo, hs, th} = '0;
        repeat (15) @(posedge clk);
        #1;
        chk(1'b0);
        rst_n = 1'b1;
        t_quiet();
        t_detect();
        t_values();
        t_state();
        t_reset();
        complete_run();
    end
endmodule
